/* src/pscr_phy_ctrl.sv */
// Strap capture, per-port control and advertisement registers, and the serial management slave.
`timescale 1ns/1ps
`include "pscr_consts.svh"

module pscr_phy_ctrl #(
  parameter logic [15:0] ID_HIGH = 16'h0a5a,  // Arbitrary neutral identifier value.
  parameter logic [15:0] ID_LOW  = 16'h5a51   // Arbitrary neutral identifier value.
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          ce,
  input  wire logic                          mdc,
  input  wire logic                          mdio_in,
  output logic                               mdio_out,
  output logic                               mdio_oe,
  input  wire pscr_pkg::pscr_strap_t         straps,
  input  wire logic [3:0]                    an_speed_in,
  input  wire logic [3:0]                    an_duplex_in,
  input  wire logic [3:0][15:0]              status_in,
  input  wire logic [3:0][15:0]              partner_in,
  output pscr_pkg::pscr_ctrl_t [3:0]         ctrl_out,
  output logic [3:0]                         phy_reset_pulse,
  output logic [3:0]                         an_restart_pulse,
  output logic [3:0][4:0]                    port_addr,
  output logic                               fibre_mode,
  output logic                               test_mode,
  output logic                               led_active_low
);

  //////////////////////////////////////////////////////////////////////////////////////////////

  // The mapping is its own inverse, so it serves both address-to-port and port-to-address.
  function automatic logic [1:0] addr_to_port(input logic [1:0] low, input logic order);
    return order ? low : ~low;
  endfunction : addr_to_port

  function automatic logic is_fibre(input logic [1:0] p, input pscr_pkg::pscr_strap_t s);
    return !s.fibre_n && (p == `PSCR_FIBRE_PORT);
  endfunction : is_fibre

  function automatic pscr_pkg::pscr_ctrl_t ctrl_default(input logic [1:0] p,
                                                        input pscr_pkg::pscr_strap_t s);
    pscr_pkg::pscr_ctrl_t c;
    c = '0;
    c.an_enable = s.autoneg_strap & ~is_fibre(p, s);
    c.speed     = is_fibre(p, s) | (s.forced_speed_strap & ~s.autoneg_strap);
    c.duplex    = s.duplex_strap;
    return c;
  endfunction : ctrl_default

  function automatic logic [15:0] adv_default(input pscr_pkg::pscr_strap_t s);
    logic [15:0] a;
    a = `PSCR_ADV_RESET;
    a[`PSCR_ADV_PAUSE] = s.pause;
    a[`PSCR_ADV_TXFD]  = s.autoneg_strap ? s.duplex_strap : 1'b1;
    a[`PSCR_ADV_10FD]  = s.autoneg_strap ? s.duplex_strap : 1'b1;
    return a;
  endfunction : adv_default

  //////////////////////////////////////////////////////////////////////////////////////////////

  pscr_pkg::pscr_strap_t      strap_r;
  logic                       strap_done_r;
  pscr_pkg::pscr_ctrl_t [3:0] ctrl_r;
  logic [3:0][15:0]           adv_r;
  pscr_pkg::pscr_state_t      state_r;
  logic [4:0]                 cnt_r;
  logic [15:0]                sh_r;
  logic                       rd_r;
  logic                       hit_r;
  logic [1:0]                 port_sel_r;
  logic [4:0]                 reg_sel_r;
  logic                       mdc_prev_r;
  logic                       mdio_out_r;
  logic                       mdio_oe_r;
  pscr_pkg::pscr_ctrl_t [3:0] ctrl_out_r;
  logic [3:0]                 phy_reset_r;
  logic [3:0]                 an_restart_r;
  logic [3:0][4:0]            port_addr_r;
  logic                       fibre_mode_r;
  logic                       test_mode_r;
  logic                       led_r;
  logic [15:0]                rd_word_w;
  wire pscr_pkg::pscr_ctrl_t [3:0] eff_ctrl;

  wire        mdc_rise = mdc & ~mdc_prev_r;
  wire [11:0] hdr_w    = {sh_r[10:0], mdio_in};
  wire [15:0] wr_data  = {sh_r[14:0], mdio_in};
  wire        hdr_end  = mdc_rise && (state_r == pscr_pkg::st_hdr) && (cnt_r == `PSCR_HDR_LAST);
  wire        data_end = mdc_rise && (state_r == pscr_pkg::st_data) && (cnt_r == `PSCR_DATA_LAST);
  wire        wr_en    = data_end && !rd_r && hit_r;
  wire        wr_ctrl  = wr_en && (reg_sel_r == `PSCR_REG_CTRL);
  wire        wr_adv   = wr_en && (reg_sel_r == `PSCR_REG_ADV);
  wire        sel_fib  = is_fibre(port_sel_r, strap_r);
  wire        op_ok    = (hdr_w[11:10] == `PSCR_OP_READ) || (hdr_w[11:10] == `PSCR_OP_WRITE);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Effective per-port controls: what drives the port, and what is read back for speed, negotiation and duplex.

  for (genvar g = 0; g < 4; g++) begin : g_eff
    wire fib_w = is_fibre(2'(g), strap_r);
    wire spd_w = fib_w | (ctrl_r[g].an_enable ? an_speed_in[g] : ctrl_r[g].speed);
    assign eff_ctrl[g] = '{
      loopback:   ctrl_r[g].loopback & ~spd_w,
      speed:      spd_w,
      an_enable:  ctrl_r[g].an_enable & ~fib_w,
      power_down: ctrl_r[g].power_down,
      isolate:    ctrl_r[g].isolate,
      duplex:     (ctrl_r[g].an_enable && !fib_w) ? an_duplex_in[g] : ctrl_r[g].duplex
    };
  end

  always_comb begin
    rd_word_w = 16'h0000;
    case (reg_sel_r)
      `PSCR_REG_CTRL: rd_word_w = {1'b0, ctrl_r[port_sel_r].loopback,
                                   eff_ctrl[port_sel_r].speed, eff_ctrl[port_sel_r].an_enable,
                                   ctrl_r[port_sel_r].power_down, ctrl_r[port_sel_r].isolate,
                                   1'b0, eff_ctrl[port_sel_r].duplex, 8'h00};
      `PSCR_REG_STAT:  rd_word_w = status_in[port_sel_r];
      `PSCR_REG_ID_HI: rd_word_w = ID_HIGH;
      `PSCR_REG_ID_LO: rd_word_w = ID_LOW;
      `PSCR_REG_ADV:   rd_word_w = adv_r[port_sel_r];
      `PSCR_REG_LPA:   rd_word_w = partner_in[port_sel_r];
      default:         rd_word_w = 16'h0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Straps are taken on the first enabled edge after reset and then held for good.

  always_ff @(posedge clk) begin
    if (reset) begin
      strap_r      <= '0;
      strap_done_r <= 1'b0;
      port_addr_r  <= '0;
    end else if (ce && !strap_done_r) begin
      strap_r      <= straps;
      strap_done_r <= 1'b1;
      for (int p = 0; p < 4; p++) begin
        port_addr_r[p] <= {straps.addr_hi, addr_to_port(2'(p), straps.order)};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r       <= '0;
      adv_r        <= '0;
      phy_reset_r  <= 4'h0;
      an_restart_r <= 4'h0;
    end else if (ce) begin
      phy_reset_r  <= 4'h0;
      an_restart_r <= 4'h0;
      if (!strap_done_r) begin
        for (int p = 0; p < 4; p++) begin
          ctrl_r[p] <= ctrl_default(2'(p), straps);
          adv_r[p]  <= adv_default(straps);
        end
      end else if (wr_ctrl && wr_data[`PSCR_B_RESET]) begin
        // A port reset returns that port's registers to their strap defaults.
        ctrl_r[port_sel_r]      <= ctrl_default(port_sel_r, strap_r);
        adv_r[port_sel_r]       <= adv_default(strap_r);
        phy_reset_r[port_sel_r] <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_r[port_sel_r].loopback   <= wr_data[`PSCR_B_LOOP];
        ctrl_r[port_sel_r].power_down <= wr_data[`PSCR_B_PDN];
        ctrl_r[port_sel_r].isolate    <= wr_data[`PSCR_B_ISO];
        if (!sel_fib) begin
          ctrl_r[port_sel_r].an_enable <= wr_data[`PSCR_B_ANEN];
        end
        if (!sel_fib && !ctrl_r[port_sel_r].an_enable) begin
          ctrl_r[port_sel_r].speed <= wr_data[`PSCR_B_SPD];
        end
        if (sel_fib || !ctrl_r[port_sel_r].an_enable) begin
          ctrl_r[port_sel_r].duplex <= wr_data[`PSCR_B_DPX];
        end
        an_restart_r[port_sel_r] <= wr_data[`PSCR_B_RSTAN];
      end else if (wr_adv) begin
        adv_r[port_sel_r] <= (adv_r[port_sel_r] & ~`PSCR_ADV_WMASK) |
                             (wr_data & `PSCR_ADV_WMASK);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Management frame engine; preamble may be suppressed, so a 0 then 1 starts a frame.
  // It never looks at power-down or isolate, so management keeps answering in both.

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r    <= pscr_pkg::st_idle;
      cnt_r      <= 5'h00;
      sh_r       <= 16'h0000;
      rd_r       <= 1'b0;
      hit_r      <= 1'b0;
      port_sel_r <= 2'h0;
      reg_sel_r  <= 5'h00;
      // A master may leave its clock high across reset; a high start level avoids a false edge.
      mdc_prev_r <= 1'b1;
      mdio_out_r <= 1'b0;
      mdio_oe_r  <= 1'b0;
    end else if (ce) begin
      mdc_prev_r <= mdc;
      if (mdc_rise) begin
        case (state_r)
          pscr_pkg::st_idle: begin
            if (!mdio_in) state_r <= pscr_pkg::st_start;
          end
          pscr_pkg::st_start: begin
            state_r <= mdio_in ? pscr_pkg::st_hdr : pscr_pkg::st_idle;
            cnt_r   <= 5'h00;
          end
          pscr_pkg::st_hdr: begin
            sh_r  <= wr_data;
            cnt_r <= cnt_r + 5'h01;
            if (hdr_end) begin
              // Frames for other addresses are still walked through to stay in step.
              state_r    <= op_ok ? pscr_pkg::st_ta : pscr_pkg::st_idle;
              cnt_r      <= 5'h00;
              rd_r       <= (hdr_w[11:10] == `PSCR_OP_READ);
              hit_r      <= strap_done_r && (hdr_w[9:7] == strap_r.addr_hi);
              port_sel_r <= addr_to_port(hdr_w[6:5], strap_r.order);
              reg_sel_r  <= hdr_w[4:0];
            end
          end
          pscr_pkg::st_ta: begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == 5'h00) begin
              sh_r       <= rd_word_w;
              mdio_oe_r  <= rd_r && hit_r;
              mdio_out_r <= 1'b0;
            end else begin
              state_r    <= pscr_pkg::st_data;
              cnt_r      <= 5'h00;
              mdio_out_r <= sh_r[15];
              sh_r       <= {sh_r[14:0], 1'b0};
            end
          end
          pscr_pkg::st_data: begin
            cnt_r <= cnt_r + 5'h01;
            if (rd_r) begin
              mdio_out_r <= sh_r[15];
              sh_r       <= {sh_r[14:0], 1'b0};
            end else begin
              sh_r <= wr_data;
            end
            if (data_end) begin
              state_r    <= pscr_pkg::st_idle;
              mdio_oe_r  <= 1'b0;
              mdio_out_r <= 1'b0;
            end
          end
          default: state_r <= pscr_pkg::st_idle;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_out_r   <= '0;
      fibre_mode_r <= 1'b0;
      test_mode_r  <= 1'b0;
      led_r        <= 1'b0;
    end else if (ce) begin
      ctrl_out_r   <= eff_ctrl;
      fibre_mode_r <= strap_done_r & ~strap_r.fibre_n;
      test_mode_r  <= strap_done_r & ~strap_r.test_n;
      led_r        <= strap_done_r & strap_r.led_pol;
    end
  end

  assign mdio_out         = mdio_out_r;
  assign mdio_oe          = mdio_oe_r;
  assign ctrl_out         = ctrl_out_r;
  assign phy_reset_pulse  = phy_reset_r;
  assign an_restart_pulse = an_restart_r;
  assign port_addr        = port_addr_r;
  assign fibre_mode       = fibre_mode_r;
  assign test_mode        = test_mode_r;
  assign led_active_low   = led_r;

  //////////////////////////////////////////////////////////////////////////////////////////////

  AST_FIBRE_RO: assert property (@(posedge clk) disable iff (reset)
    strap_done_r && !strap_r.fibre_n |-> eff_ctrl[3].speed && !ctrl_r[3].an_enable)
    else $error("fibre port speed or negotiation wrong");
  AST_ADDR_ORDER: assert property (@(posedge clk) disable iff (reset)
    strap_done_r |-> port_addr_r[0][1:0] == (strap_r.order ? 2'h0 : 2'h3) &&
                     port_addr_r[3][1:0] == (strap_r.order ? 2'h3 : 2'h0))
    else $error("port address order wrong");
  AST_STRAP_CTRL: assert property (@(posedge clk) disable iff (reset)
    $rose(strap_done_r) |-> ctrl_r[0].an_enable == strap_r.autoneg_strap &&
                            (strap_r.autoneg_strap || ctrl_r[0].speed == strap_r.forced_speed_strap))
    else $error("control defaults do not follow straps");
  AST_STRAP_ADV: assert property (@(posedge clk) disable iff (reset)
    $rose(strap_done_r) |-> adv_r[1][10] == strap_r.pause &&
                            (!strap_r.autoneg_strap || adv_r[1][8] == strap_r.duplex_strap))
    else $error("advertisement defaults do not follow straps");
  AST_RESET_PULSE: assert property (@(posedge clk) disable iff (reset)
    ce && strap_done_r && wr_ctrl && wr_data[`PSCR_B_RESET] |=> phy_reset_r[port_sel_r])
    else $error("port reset pulse missing");
  AST_RESTART_PULSE: assert property (@(posedge clk) disable iff (reset)
    ce && strap_done_r && wr_ctrl && !wr_data[15] && wr_data[9] |=> an_restart_r[port_sel_r])
    else $error("negotiation restart pulse missing");
  AST_DPX_LOCK: assert property (@(posedge clk) disable iff (reset)
    ce && strap_done_r && wr_ctrl && !wr_data[15] && !sel_fib && ctrl_r[port_sel_r].an_enable
    |=> ctrl_r[port_sel_r].duplex == $past(ctrl_r[port_sel_r].duplex))
    else $error("duplex written while negotiating");
  AST_MGMT_ANSWER: assert property (@(posedge clk) disable iff (reset)
    ce && mdc_rise && state_r == pscr_pkg::st_ta && cnt_r == 5'h00 && rd_r && hit_r
    |=> mdio_oe_r && !mdio_out_r)
    else $error("management read not answered");
  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (reset)
    reg_sel_r > `PSCR_REG_LPA || reg_sel_r == `PSCR_REG_CTRL |-> rd_word_w[7:0] == 8'h00)
    else $error("reserved bits read nonzero");

endmodule : pscr_phy_ctrl

/* src/pscr_consts.svh */
// Register indices, field positions, reset values and frame counts of the strap/control block.
`ifndef PSCR_CONSTS_SVH
`define PSCR_CONSTS_SVH

`define PSCR_REG_CTRL   5'h00
`define PSCR_REG_STAT   5'h01
`define PSCR_REG_ID_HI  5'h02
`define PSCR_REG_ID_LO  5'h03
`define PSCR_REG_ADV    5'h04
`define PSCR_REG_LPA    5'h05

`define PSCR_B_RESET    15
`define PSCR_B_LOOP     14
`define PSCR_B_SPD      13
`define PSCR_B_ANEN     12
`define PSCR_B_PDN      11
`define PSCR_B_ISO      10
`define PSCR_B_RSTAN    9
`define PSCR_B_DPX      8

`define PSCR_ADV_PAUSE  10
`define PSCR_ADV_TXFD   8
`define PSCR_ADV_10FD   6
`define PSCR_ADV_RESET  16'h01e1
`define PSCR_ADV_WMASK  16'h25e0

`define PSCR_OP_READ    2'h2
`define PSCR_OP_WRITE   2'h1
`define PSCR_HDR_LAST   5'h0b
`define PSCR_DATA_LAST  5'h0f
`define PSCR_FIBRE_PORT 2'h3

`endif

/* src/pscr_pkg.sv */
// Types shared by the strap capture and management control logic.
package pscr_pkg;

  typedef enum logic [2:0] {
    st_idle  = 3'h0,
    st_start = 3'h1,
    st_hdr   = 3'h3,
    st_ta    = 3'h2,
    st_data  = 3'h6
  } pscr_state_t;

  typedef struct packed {
    logic       fibre_n;
    logic [2:0] addr_hi;
    logic       order;
    logic       forced_speed_strap;
    logic       autoneg_strap;
    logic       duplex_strap;
    logic       pause;
    logic       test_n;
    logic       led_pol;
  } pscr_strap_t;

  typedef struct packed {
    logic loopback;
    logic speed;
    logic an_enable;
    logic power_down;
    logic isolate;
    logic duplex;
  } pscr_ctrl_t;

endpackage : pscr_pkg

/* sim/pscr_mac_model.sv */
// Management master model that clocks frames out on the serial management lines.
`timescale 1ns/1ps
module pscr_mac_model (
  input  wire logic clk,
  input  wire logic mdio,
  output logic      mdc,
  output logic      mac_out,
  output logic      mac_oe
);
  initial begin
    mdc = 1'b0;
    mac_out = 1'b1;
    mac_oe = 1'b0;
  end

  // Data changes only while the clock line is low; hp is the low time in clk cycles, and the high time is hp + 1.
  task automatic bit_cyc(input logic oe, input logic v, input int hp, output logic smp);
    @(posedge clk);
    mdc <= 1'b0;
    mac_oe <= oe;
    mac_out <= v;
    repeat (hp) @(posedge clk);
    smp = mdio;
    mdc <= 1'b1;
    repeat (hp) @(posedge clk);
  endtask : bit_cyc

  // Released line floats to the pull-up level, so turnaround and read data are undriven here.
  // Only op 10 releases the line for turnaround and data; any other code is driven throughout.
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, input int hp, output logic [15:0] q);
    logic [31:0] hdr;
    logic        s;
    hdr = {2'b01, op, pa, ra, 2'b10, wd};
    q = 16'h0000;
    for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, hp, s);
    for (int i = 31; i >= 0; i--) begin
      bit_cyc(!(op == 2'b10 && i < 18), hdr[i], hp, s);
      if (i < 16) q[i] = s;
    end
    bit_cyc(1'b0, 1'b1, hp, s);
  endtask : frame
endmodule : pscr_mac_model

/* sim/tb_phy_strap_and_control_reg.sv */
// Self-checking bench for strap capture, address map and management registers.
`timescale 1ns/1ps
`include "pscr_consts.svh"
module tb_phy_strap_and_control_reg;
  localparam logic [15:0] ID_HI = 16'h1357;  // Arbitrary value.
  localparam logic [15:0] ID_LO = 16'h2468;  // Arbitrary value.
  logic                       clk, reset, ce, mdc, mdio, mac_out, mac_oe, mdio_out, mdio_oe;
  pscr_pkg::pscr_strap_t      straps, s;
  logic [3:0]                 an_speed_in, an_duplex_in, phy_reset_pulse, an_restart_pulse;
  logic [3:0][15:0]           status_in, partner_in;
  pscr_pkg::pscr_ctrl_t [3:0] ctrl_out;
  logic [3:0][4:0]            port_addr;
  logic                       fibre_mode, test_mode, led_active_low;
  logic [15:0]                q, w;
  int                         err_count, comparisons;
  int                         rst_pulses = 0;
  int                         an_pulses = 0;

  assign mdio = mdio_oe ? mdio_out : (mac_oe ? mac_out : 1'b1);

  pscr_phy_ctrl #(.ID_HIGH(ID_HI), .ID_LOW(ID_LO)) i_pscr_phy_ctrl (
    .clk(clk), .reset(reset), .ce(ce), .mdc(mdc), .mdio_in(mdio), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .straps(straps), .an_speed_in(an_speed_in),
    .an_duplex_in(an_duplex_in), .status_in(status_in), .partner_in(partner_in),
    .ctrl_out(ctrl_out), .phy_reset_pulse(phy_reset_pulse),
    .an_restart_pulse(an_restart_pulse), .port_addr(port_addr), .fibre_mode(fibre_mode),
    .test_mode(test_mode), .led_active_low(led_active_low));

  pscr_mac_model i_pscr_mac_model (.clk(clk), .mdio(mdio), .mdc(mdc), .mac_out(mac_out),
                                   .mac_oe(mac_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    rst_pulses <= rst_pulses + $countones(phy_reset_pulse);
    an_pulses <= an_pulses + $countones(an_restart_pulse);
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] pa(input logic [1:0] p);
    return {s.addr_hi, s.order ? p : 2'h3 - p};
  endfunction : pa

  function automatic logic [15:0] ctl_dflt(input logic [1:0] p);
    logic fib, an, spd, dpx;
    fib = (p == `PSCR_FIBRE_PORT) && !s.fibre_n;
    an = s.autoneg_strap && !fib;
    spd = fib ? 1'b1 : (an ? an_speed_in[p] : s.forced_speed_strap);
    dpx = an ? an_duplex_in[p] : s.duplex_strap;
    return {2'h0, spd, an, 3'h0, dpx, 8'h00};
  endfunction : ctl_dflt

  function automatic logic [15:0] reg_exp(input logic [1:0] p, input int r);
    logic d;
    d = s.autoneg_strap ? s.duplex_strap : 1'b1;
    case (r)
      0: return ctl_dflt(p);
      1: return status_in[p];
      2: return ID_HI;
      3: return ID_LO;
      4: return {5'h00, s.pause, 1'b0, d, 1'b1, d, 6'h21};
      5: return partner_in[p];
      default: return 16'h0000;
    endcase
  endfunction : reg_exp

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rd(input logic [1:0] p, input int r, input int hp);
    i_pscr_mac_model.frame(`PSCR_OP_READ, pa(p), 5'(r), 16'h0000, hp, q);
  endtask : rd

  task automatic wr(input logic [1:0] p, input int r, input logic [15:0] d, input int hp);
    i_pscr_mac_model.frame(`PSCR_OP_WRITE, pa(p), 5'(r), d, hp, q);
    repeat (3) @(posedge clk);
  endtask : wr

  task automatic finish_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    #800000;
    err_count++;
    $display("FAIL watchdog expected finish seen timeout");
    finish_test();
  end

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    straps = '0;
    s = '0;
    an_speed_in = 4'h0;
    an_duplex_in = 4'h0;
    status_in = '0;
    partner_in = '0;
    err_count = 0;
    comparisons = 0;
    void'($urandom(90741));
    for (int it = 0; it < 2; it++) begin
      // Two strap sets cover both address orders and both fibre settings.
      s = pscr_pkg::pscr_strap_t'(12'($urandom));
      s.order = it[0];
      s.autoneg_strap = it[0];
      s.fibre_n = it[0];
      s.test_n = it[0];
      @(posedge clk);
      reset <= 1'b1;
      straps <= s;
      an_speed_in <= 4'($urandom);
      an_duplex_in <= 4'($urandom);
      status_in <= {$urandom, $urandom};
      partner_in <= {$urandom, $urandom};
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      check("ce freeze", 16'h0000, 16'({port_addr[0], port_addr[3]}));
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      for (int p = 0; p < 4; p++) check("port_addr", 16'(pa(2'(p))), 16'(port_addr[p]));
      check("fibre_mode", 16'(!s.fibre_n), 16'(fibre_mode));
      check("test_mode", 16'(!s.test_n), 16'(test_mode));
      check("led_active_low", 16'(s.led_pol), 16'(led_active_low));
      for (int p = 0; p < 4; p++) begin
        for (int r = 0; r < 8; r++) begin
          rd(2'(p), r, 1 + 2 * (r % 2));
          check("register read", reg_exp(2'(p), r), q);
        end
      end
      i_pscr_mac_model.frame(`PSCR_OP_READ, {~s.addr_hi, 2'h0}, 5'h00, 16'h0000, 1, q);
      check("unselected read", 16'hffff, q);
      w = 16'($urandom);
      wr(2'h2, 4, w, 2);
      rd(2'h2, 4, 1);
      check("advertise write", (w & 16'h25e0) | 16'h0001, q);
      i_pscr_mac_model.frame({2{it[0]}}, pa(2'h2), 5'h04, 16'hffff, 1, q);
      rd(2'h2, 4, 1);
      check("invalid op ignored", (w & 16'h25e0) | 16'h0001, q);
      if (it == 0) begin
        wr(2'h0, 0, 16'h4dff, 1);
        rd(2'h0, 0, 3);
        check("control write", 16'h4d00, q);
        check("ctrl_out", 16'h0027, 16'(ctrl_out[0]));
        wr(2'h0, 0, 16'h6000, 1);
        check("ctrl_out", 16'h0010, 16'(ctrl_out[0]));
        wr(2'h0, 0, 16'h0200, 2);
        rd(2'h0, 0, 1);
        check("restart readback", 16'h0000, q);
        wr(2'h0, 0, 16'h8000, 1);
        rd(2'h0, 0, 1);
        check("reset readback", ctl_dflt(2'h0), q);
        check("an_restart_pulse", 16'h0001, 16'(an_pulses));
        check("phy_reset_pulse", 16'h0001, 16'(rst_pulses));
        wr(2'h3, 0, 16'h1000, 3);
        rd(2'h3, 0, 1);
        check("fibre control", 16'h2000, q);
      end else begin
        wr(2'h1, 0, 16'h3100, 1);
        rd(2'h1, 0, 2);
        check("negotiated control", {2'h0, an_speed_in[1], 4'h8, an_duplex_in[1], 8'h00}, q);
      end
      $display("test %0d done", it);
    end
    finish_test();
  end
endmodule : tb_phy_strap_and_control_reg
